// ### design/tws_pkg.sv
// Contract
// - Reset clears control register to zero
// - Disabled: shift stopped, counter cleared, pins released
// - Clock select: external, div4, div8, div16
// - No transfer starts unless enable is set
// - Transmit/receive: shift write starts, output driven
// - Receive-only: shift read starts, output released
// - Write while disabled never starts later
// - Exactly eight bits per transfer, full duplex
// - Shift on falling edge via output latch
// - Sample input on rising serial clock edge
// - Output pin changes only at shift edge
// - Transfer begins with a falling clock edge
// - Stop after eighth bit, flag completion
// - Internal clock rests high after transfer
// - Internal clock: master drives clock pin
// - Unused data pins stay free for port
// - Most significant bit sent and received first
// - Reset clears shift register to zero
package tws_pkg;
	localparam logic [15:0] CTRL_ADDR    = 16'hffa8;
	localparam logic [15:0] SHIFT_ADDR   = 16'hffa9;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  SHIFT_RESET  = 8'h00;
	localparam int          ENABLE_BIT   = 7;
	localparam int          MODE_BIT     = 2;
	localparam logic [7:0]  CTRL_MASK    = 8'h87;
	localparam logic [1:0]  CLK_EXT      = 2'h0;
	localparam logic [1:0]  CLK_DIV4     = 2'h1;
	localparam logic [1:0]  CLK_DIV8     = 2'h2;
	localparam logic [1:0]  CLK_DIV16    = 2'h3;
	// Half serial periods in system clocks, less one
	localparam logic [2:0]  HALF_DIV4    = 3'h1;
	localparam logic [2:0]  HALF_DIV8    = 3'h3;
	localparam logic [2:0]  HALF_DIV16   = 3'h7;
	localparam logic [2:0]  LAST_BIT     = 3'h7;
	localparam logic [2:0]  COUNT_RESET  = 3'h0;
	typedef enum logic [2:0] {
		TWS_IDLE  = 3'h1,
		TWS_ARMED = 3'h2,
		TWS_SHIFT = 3'h4
	} tws_state_t;
endpackage

// ### design/tws_input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tws_input_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clock_in,   // System clock
	input  wire logic reset_in,   // Synchronous reset
	input  wire logic clk_en_in,  // Freezes state when low
	input  wire logic pin_in,     // Asynchronous pin
	output logic      level_out   // Filtered level
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	always_comb begin
		next_stage = {stage[1:0], pin_in};
		next_level = level_out;
		// Accept a change once the second and third stages agree
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			stage     <= {3{RESET_LEVEL}};
			level_out <= RESET_LEVEL;
		end else if (clk_en_in) begin
			stage     <= next_stage;
			level_out <= next_level;
		end
	end
endmodule
`default_nettype wire

// ### design/tws_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tws_clock_divider (
	input  wire logic       clock_in,   // System clock
	input  wire logic       reset_in,   // Synchronous reset
	input  wire logic       clk_en_in,  // Freezes state when low
	input  wire logic       restart_in, // Restart half period
	input  wire logic [1:0] select_in,  // Clock select field
	output logic            tick_out    // Half period elapsed
);
	logic [2:0] count;
	logic [2:0] next_count;
	logic [2:0] limit;

	always_comb begin
		unique case (select_in)
			tws_pkg::CLK_DIV4: limit = tws_pkg::HALF_DIV4;
			tws_pkg::CLK_DIV8: limit = tws_pkg::HALF_DIV8;
			default:           limit = tws_pkg::HALF_DIV16;
		endcase
		tick_out   = !restart_in && (count == limit);
		next_count = count + 3'h1;
		if (restart_in || tick_out) begin
			next_count = tws_pkg::COUNT_RESET;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			count <= tws_pkg::COUNT_RESET;
		end else if (clk_en_in) begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// ### design/tws_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module tws_serial_port (
	input  wire logic        clock_in,    // System clock, 20 MHz
	input  wire logic        reset_in,    // Synchronous reset, active high
	input  wire logic        clk_en_in,   // Freezes all state when low
	input  wire logic [15:0] addr_in,     // Register address
	input  wire logic        wr_in,       // Register write strobe
	input  wire logic        rd_in,       // Register read strobe
	input  wire logic [7:0]  wdata_in,    // Write data
	output logic      [7:0]  rdata_out,   // Read data, one cycle later
	input  wire logic        sck_in,      // Serial clock pin input
	output logic             sck_out,     // Serial clock pin output
	output logic             sck_oe_out,  // Serial clock pin drive enable
	output logic             so_out,      // Serial out pin output
	output logic             so_oe_out,   // Serial out pin drive enable
	input  wire logic        si_in,       // Serial in pin input
	output logic             busy_out,    // Transfer in progress
	output logic             done_out     // Transfer complete pulse
);
	tws_pkg::tws_state_t state;
	tws_pkg::tws_state_t next_state;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [7:0] next_rdata;
	logic       next_sck;
	logic       next_sck_oe;
	logic       next_so;
	logic       next_so_oe;
	logic       next_busy;
	logic       next_done;
	logic       ext_prev;
	logic       ext_level;
	logic       si_level;
	logic       tick;
	logic       enabled;
	logic       rx_only;
	logic       internal;
	logic       wr_ctrl;
	logic       wr_shift;
	logic       rd_shift;
	logic       trigger;
	logic       fall_evt;
	logic       rise_evt;

	tws_input_sync #(
		.RESET_LEVEL (1'b1)
	) u_sck_sync (
		.clock_in  (clock_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.pin_in    (sck_in),
		.level_out (ext_level)
	);

	tws_input_sync #(
		.RESET_LEVEL (1'b0)
	) u_si_sync (
		.clock_in  (clock_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.pin_in    (si_in),
		.level_out (si_level)
	);

	tws_clock_divider u_divider (
		.clock_in   (clock_in),
		.reset_in   (reset_in),
		.clk_en_in  (clk_en_in),
		.restart_in (trigger),
		.select_in  (ctrl[1:0]),
		.tick_out   (tick)
	);

	// Decode and serial clock events
	always_comb begin
		enabled  = ctrl[tws_pkg::ENABLE_BIT];
		rx_only  = ctrl[tws_pkg::MODE_BIT];
		internal = ctrl[1:0] != tws_pkg::CLK_EXT;
		wr_ctrl  = wr_in && (addr_in == tws_pkg::CTRL_ADDR);
		wr_shift = wr_in && (addr_in == tws_pkg::SHIFT_ADDR);
		rd_shift = rd_in && (addr_in == tws_pkg::SHIFT_ADDR);
		// Start only on an access while enabled and idle
		trigger  = enabled && (state == tws_pkg::TWS_IDLE)
			&& ((!rx_only && wr_shift) || (rx_only && rd_shift));
		if (internal) begin
			fall_evt = trigger || ((state == tws_pkg::TWS_SHIFT) && tick && sck_out);
			rise_evt = (state == tws_pkg::TWS_SHIFT) && tick && !sck_out;
		end else begin
			fall_evt = (state != tws_pkg::TWS_IDLE) && ext_prev && !ext_level;
			rise_evt = (state == tws_pkg::TWS_SHIFT) && !ext_prev && ext_level;
		end
	end

	// Transfer sequencing and shift register
	always_comb begin
		next_state   = state;
		next_shift   = shift;
		next_bit_cnt = bit_cnt;
		next_done    = 1'b0;
		next_so      = so_out;
		// Loads only while idle, so a disabled write waits for a new trigger
		if (wr_shift && (state == tws_pkg::TWS_IDLE)) begin
			next_shift = wdata_in;
		end
		unique case (state)
			tws_pkg::TWS_IDLE: begin
				if (trigger) begin
					next_state = internal ? tws_pkg::TWS_SHIFT : tws_pkg::TWS_ARMED;
				end
			end
			tws_pkg::TWS_ARMED: begin
				if (fall_evt) begin
					next_state = tws_pkg::TWS_SHIFT;
				end
			end
			tws_pkg::TWS_SHIFT: begin
				if (rise_evt) begin
					next_shift   = {shift[6:0], si_level};
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == tws_pkg::LAST_BIT) begin
						next_state = tws_pkg::TWS_IDLE;
						next_done  = 1'b1;
					end
				end
			end
			default: begin
				next_state = tws_pkg::TWS_IDLE;
			end
		endcase
		// Output latch takes the top bit at each shift edge, from the write data on a write start
		if (fall_evt) begin
			next_so = (trigger && !rx_only) ? wdata_in[7] : shift[7];
		end
		if (!enabled) begin
			next_state   = tws_pkg::TWS_IDLE;
			next_bit_cnt = tws_pkg::COUNT_RESET;
			next_done    = 1'b0;
		end
		next_busy = next_state != tws_pkg::TWS_IDLE;
	end

	// Pin control and register reads
	always_comb begin
		next_ctrl   = ctrl;
		next_rdata  = rdata_out;
		next_sck    = 1'b1;
		next_sck_oe = enabled && internal;
		next_so_oe  = enabled && !rx_only;
		if (wr_ctrl) begin
			next_ctrl = wdata_in & tws_pkg::CTRL_MASK;
		end
		if (enabled && internal) begin
			if (trigger) begin
				next_sck = 1'b0;
			end else if (state == tws_pkg::TWS_SHIFT) begin
				next_sck = tick ? !sck_out : sck_out;
			end
		end
		if (rd_in) begin
			if (addr_in == tws_pkg::CTRL_ADDR) begin
				next_rdata = ctrl & tws_pkg::CTRL_MASK;
			end else if (addr_in == tws_pkg::SHIFT_ADDR) begin
				next_rdata = shift;
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state      <= tws_pkg::TWS_IDLE;
			ctrl       <= tws_pkg::CTRL_RESET;
			shift      <= tws_pkg::SHIFT_RESET;
			bit_cnt    <= tws_pkg::COUNT_RESET;
			rdata_out  <= 8'h00;
			sck_out    <= 1'b1;
			sck_oe_out <= 1'b0;
			so_out     <= 1'b0;
			so_oe_out  <= 1'b0;
			busy_out   <= 1'b0;
			done_out   <= 1'b0;
			ext_prev   <= 1'b1;
		end else if (clk_en_in) begin
			state      <= next_state;
			ctrl       <= next_ctrl;
			shift      <= next_shift;
			bit_cnt    <= next_bit_cnt;
			rdata_out  <= next_rdata;
			sck_out    <= next_sck;
			sck_oe_out <= next_sck_oe;
			so_out     <= next_so;
			so_oe_out  <= next_so_oe;
			busy_out   <= next_busy;
			done_out   <= next_done;
			ext_prev   <= ext_level;
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);

	property p_reset_values;
		$fell(reset_in) |-> (ctrl == tws_pkg::CTRL_RESET) && (shift == tws_pkg::SHIFT_RESET);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("registers not cleared by reset");

	property p_disabled_release;
		clk_en_in && !enabled |=> (bit_cnt == 3'h0) && !sck_oe_out && !so_oe_out && !busy_out;
	endproperty
	a_disabled_release: assert property (p_disabled_release)
		else $error("disabled port still active");

	property p_no_start_disabled;
		clk_en_in && !enabled && (state == tws_pkg::TWS_IDLE)
			|=> (state == tws_pkg::TWS_IDLE);
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled)
		else $error("transfer started while disabled");

	property p_write_starts;
		clk_en_in && enabled && !rx_only && wr_shift && (state == tws_pkg::TWS_IDLE)
			|=> busy_out && so_oe_out;
	endproperty
	a_write_starts: assert property (p_write_starts)
		else $error("shift write did not start transfer");

	property p_read_starts;
		clk_en_in && enabled && rx_only && rd_shift && (state == tws_pkg::TWS_IDLE)
			|=> busy_out && !so_oe_out;
	endproperty
	a_read_starts: assert property (p_read_starts)
		else $error("shift read did not start transfer");

	property p_eighth_bit_ends;
		clk_en_in && enabled && rise_evt && (bit_cnt == 3'h7)
			|=> done_out && (state == tws_pkg::TWS_IDLE) ##1 !done_out;
	endproperty
	a_eighth_bit_ends: assert property (p_eighth_bit_ends)
		else $error("transfer did not end after eight bits");

	property p_sample_rising;
		clk_en_in && rise_evt && enabled
			|=> (shift[0] == $past(si_level)) && (shift[7:1] == $past(shift[6:0]));
	endproperty
	a_sample_rising: assert property (p_sample_rising)
		else $error("input bit not shifted in at rising edge");

	property p_out_on_fall;
		$changed(so_out) |-> $past(fall_evt);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("serial out changed away from a shift edge");

	property p_msb_first;
		clk_en_in && fall_evt && (state == tws_pkg::TWS_SHIFT) |=> so_out == $past(shift[7]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("serial out did not carry top bit");

	property p_start_on_fall;
		$rose(state == tws_pkg::TWS_SHIFT) |-> $past(fall_evt);
	endproperty
	a_start_on_fall: assert property (p_start_on_fall)
		else $error("transfer began off a falling edge");

	property p_clock_rests_high;
		clk_en_in && (state == tws_pkg::TWS_IDLE) && !trigger |=> sck_out;
	endproperty
	a_clock_rests_high: assert property (p_clock_rests_high)
		else $error("internal clock not high while idle");

	property p_master_drives;
		clk_en_in && enabled && internal |=> sck_oe_out;
	endproperty
	a_master_drives: assert property (p_master_drives)
		else $error("master not driving clock pin");

	property p_reserved_zero;
		ctrl[6:3] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bits not zero");

	property p_enable_no_start;
		clk_en_in && !enabled && wr_ctrl && wdata_in[tws_pkg::ENABLE_BIT]
			|=> !busy_out ##1 !busy_out;
	endproperty
	a_enable_no_start: assert property (p_enable_no_start)
		else $error("enabling the port started a transfer");

	property p_bit_advance;
		clk_en_in && enabled && rise_evt && (bit_cnt != tws_pkg::LAST_BIT)
			|=> (bit_cnt == $past(bit_cnt) + 3'h1) && busy_out;
	endproperty
	a_bit_advance: assert property (p_bit_advance)
		else $error("bit counter did not advance on a sample edge");
endmodule
`default_nettype wire

// ### bench/tws_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_peer_model (
	input  wire logic       clock_in,   // System clock
	input  wire logic       reset_in,   // Synchronous reset
	input  wire logic       sck_in,     // Clock line level
	input  wire logic       so_in,      // Device data out line
	input  wire logic       go_in,      // Run one clocked frame
	input  wire logic [7:0] tx_in,      // Byte to send
	output logic            si_out,     // Device data in line
	output logic            sck_out,    // Clock drive value
	output logic            sck_oe_out, // Clock drive enable
	output logic      [7:0] rx_out      // Byte received
);
	logic       sck_q;
	logic       busy;
	logic [2:0] cnt;
	logic [6:0] ph;
	assign sck_out = ph[3] | ~sck_oe_out;
	always_ff @(posedge clock_in) begin
		sck_q <= sck_in;
		if (reset_in) begin
			busy <= 1'b0;
			cnt <= 3'h0;
			sck_oe_out <= 1'b0;
			ph <= 7'h00;
			si_out <= 1'b0;
			rx_out <= 8'h00;
		end else begin
			// Eight periods, idle high
			if (go_in)
				sck_oe_out <= 1'b1;
			if (sck_oe_out)
				ph <= ph + 7'h01;
			if (ph == 7'h7f)
				sck_oe_out <= 1'b0;
			if (sck_q && !sck_in) begin
				si_out <= tx_in[~cnt];
				busy <= 1'b1;
				cnt <= cnt + 3'h1;
			end else if (!busy)
				si_out <= ~si_out;
			if (!sck_q && sck_in) begin
				rx_out <= {rx_out[6:0], so_in};
				if (cnt == 3'h0)
					busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/tws_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tws_serial_port_tb;
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [15:0] addr     = 16'h0000;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic        go       = 1'b0;
	logic        en       = 1'b1;
	logic [7:0]  wdata    = 8'h00;
	logic [7:0]  ptx      = 8'h00;
	logic [7:0]  rdata, prx, d, b;
	logic        sck_o, sck_oe, so, so_oe, si, busy, done, p_sck, p_oe, sck_q, so_q;
	int          num_errors = 0;
	int          n_tests    = 0;
	int          seed       = 72;
	int          falls, lows, bad;
	wire         sck_w = sck_oe ? sck_o : (p_oe ? p_sck : 1'b1);
	wire         so_w  = so_oe ? so : 1'b1;
	always #25 clock_in = ~clock_in;
	tws_serial_port i_dut (.clock_in(clock_in), .reset_in(reset_in), .clk_en_in(en),
		.addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata),
		.sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe), .so_out(so),
		.so_oe_out(so_oe), .si_in(si), .busy_out(busy), .done_out(done));
	tws_peer_model i_peer (.clock_in(clock_in), .reset_in(reset_in), .sck_in(sck_w),
		.so_in(so_w), .go_in(go), .tx_in(ptx), .si_out(si), .sck_out(p_sck),
		.sck_oe_out(p_oe), .rx_out(prx));
	always @(posedge clock_in) begin
		sck_q <= sck_w;
		so_q <= so;
		if (sck_q && !sck_w)
			falls++;
		if (!sck_w)
			lows++;
		// Data out moves only with an own clock fall
		if (busy && so_oe && sck_oe && so !== so_q && !(sck_q && !sck_w))
			bad++;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	function automatic logic [7:0] low_cycles(input logic [1:0] sel);
		return 8'h08 << sel;
	endfunction
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic xfer(input logic [7:0] c, input logic [7:0] v);
		int k;
		wr_reg(tws_pkg::CTRL_ADDR, c);
		// Pin drive follows the control register one cycle later
		@(posedge clock_in);
		#1;
		check({6'h0, sck_oe, so_oe}, {6'h0, c[1:0] != 2'h0, !c[2]}, "pins");
		ptx = 8'($random(seed));
		falls = 0;
		lows = 0;
		bad = 0;
		if (c[2])
			rd_reg(tws_pkg::SHIFT_ADDR, b);
		else
			wr_reg(tws_pkg::SHIFT_ADDR, v);
		check({7'h0, busy}, 8'h01, "start");
		go = (c[1:0] == 2'h0);
		@(posedge clock_in);
		#1 go = 1'b0;
		k = 0;
		// No shift access until completion
		while (done !== 1'b1 && k < 3000) begin
			@(posedge clock_in);
			#1 k++;
		end
		check({7'h0, done}, 8'h01, "completion");
		repeat (10) @(posedge clock_in);
		#1 check({6'h0, busy, sck_w}, 8'h01, "rest");
		check(falls[7:0], 8'h08, "clock falls");
		check(bad[7:0], 8'h00, "data out timing");
		if (c[1:0] != 2'h0)
			check(lows[7:0], low_cycles(c[1:0]), "clock rate");
		if (!c[2])
			check(prx, v, "sent byte");
		if (c[1:0] == 2'h0 || c[1:0] == 2'h3) begin
			// Disable first so a receive-only read starts nothing
			wr_reg(tws_pkg::CTRL_ADDR, {1'b0, c[6:0]});
			rd_reg(tws_pkg::SHIFT_ADDR, b);
			check(b, ptx, "received byte");
		end
	endtask
	initial begin
		#2000000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clock_in);
		reset_in <= 1'b0;
		rd_reg(tws_pkg::CTRL_ADDR, b);
		check(b, 8'h00, "control reset");
		rd_reg(tws_pkg::SHIFT_ADDR, b);
		check(b, 8'h00, "shift reset");
		check({4'h0, sck_oe, so_oe, busy, sck_o}, 8'h01, "idle pins");
		wr_reg(tws_pkg::CTRL_ADDR, 8'hff);
		rd_reg(tws_pkg::CTRL_ADDR, b);
		check(b, 8'h87, "control bits");
		// Clock enable low freezes the control register
		en <= 1'b0;
		wr_reg(tws_pkg::CTRL_ADDR, 8'h01);
		en <= 1'b1;
		rd_reg(tws_pkg::CTRL_ADDR, b);
		check(b, 8'h87, "frozen write");
		rd_reg(16'hffa0, b);
		check(b, 8'h00, "unmapped read");
		$display("test registers done");
		wr_reg(tws_pkg::CTRL_ADDR, 8'h01);
		wr_reg(tws_pkg::SHIFT_ADDR, 8'h5a);
		wr_reg(tws_pkg::CTRL_ADDR, 8'h81);
		lows = 0;
		repeat (40) @(posedge clock_in);
		#1 check({7'h0, busy}, 8'h00, "no late start");
		check(lows[7:0], 8'h00, "clock still");
		$display("test disabled write done");
		for (int i = 0; i < 16; i++) begin
			d = 8'($random(seed));
			if (i == 0)
				d = 8'h01;
			xfer({5'h10, i[2:0]}, d);
			$display("test transfer %0d done", i);
		end
		wr_reg(tws_pkg::CTRL_ADDR, 8'h83);
		wr_reg(tws_pkg::SHIFT_ADDR, 8'hc3);
		repeat (20) @(posedge clock_in);
		wr_reg(tws_pkg::CTRL_ADDR, 8'h03);
		repeat (2) @(posedge clock_in);
		#1 check({5'h0, busy, sck_oe, so_oe}, 8'h00, "abort");
		$display("test abort done");
		report_and_stop();
	end
endmodule
`default_nettype wire
